// file: core/tmh_pkg.sv
// Constants shared by the interval and PWM timer: addresses, fields, codes.
package tmh_pkg;

  // ----------------------------------------------------------------------
  // Register addresses on the CPU memory port
  // ----------------------------------------------------------------------
  localparam logic [15:0] TMH_ADDR_PORT4_DIRECTION = 16'hFF24;
  localparam logic [15:0] TMH_ADDR_PORT4_LATCH = 16'hFF04;
  localparam logic [15:0] TMH_ADDR_TIMER_MODE_CONTROL = 16'hFF70;
  localparam logic [15:0] TMH_ADDR_CYCLE_COMPARE = 16'hFF0E;
  localparam logic [15:0] TMH_ADDR_DUTY_COMPARE = 16'hFF0F;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] TMH_RST_PORT4_DIRECTION = 8'hFF;
  localparam logic [7:0] TMH_RST_PORT4_LATCH = 8'h00;
  localparam logic [7:0] TMH_RST_TIMER_MODE_CONTROL = 8'h00;
  localparam logic [7:0] TMH_RST_COMPARE = 8'h00;
  // Direction bits 7 and 6 always read as one.
  localparam logic [7:0] TMH_DIR_FIXED_ONES = 8'hC0;

  // ----------------------------------------------------------------------
  // Mode register field positions and the timer output pin
  // ----------------------------------------------------------------------
  localparam int TMH_BIT_TIMER_RUN = 7;
  localparam int TMH_POS_CLK_SELECT = 4;
  localparam int TMH_POS_OP_MODE = 2;
  localparam int TMH_BIT_IDLE_LEVEL_SEL = 1;
  localparam int TMH_BIT_OUT_ENABLE = 0;
  localparam int TMH_BIT_TIMER_OUT_PIN = 2;

  // ----------------------------------------------------------------------
  // Count clock selections and operating modes
  // ----------------------------------------------------------------------
  localparam logic [2:0] TMH_CKS_DIV1 = 3'h0;
  localparam logic [2:0] TMH_CKS_DIV4 = 3'h1;
  localparam logic [2:0] TMH_CKS_DIV16 = 3'h2;
  localparam logic [2:0] TMH_CKS_DIV64 = 3'h3;
  localparam logic [2:0] TMH_CKS_DIV4096 = 3'h4;
  localparam logic [2:0] TMH_CKS_SLOW128 = 3'h5;
  localparam logic [1:0] TMH_MODE_INTERVAL = 2'h0;
  localparam logic [1:0] TMH_MODE_PWM = 2'h2;

  // Prescaler masks: a tick falls where all masked bits are ones.
  localparam logic [11:0] TMH_MASK_DIV4 = 12'h003;
  localparam logic [11:0] TMH_MASK_DIV16 = 12'h00F;
  localparam logic [11:0] TMH_MASK_DIV64 = 12'h03F;
  localparam logic [11:0] TMH_MASK_DIV4096 = 12'hFFF;
  localparam logic [6:0] TMH_SLOW_LAST = 7'h7F;

  // Count clocks a new duty value must age before it may be transferred.
  localparam logic [1:0] TMH_DUTY_XFER_TICKS = 2'h3;

  // Which compare register the counter is currently chased against.
  typedef enum logic [1:0] {
    TMH_TGT_CYCLE = 2'b01,
    TMH_TGT_DUTY = 2'b10
  } tmh_target_t;

endpackage

// file: core/tmh_timer.sv
// Eight-bit interval / square-wave / PWM timer with its port 4 pin logic.
//
// Functional notes
// - Reset clears both compares and mode register to 00H; compares are R/W.
// - Duty write while running waits, moves in at match with old duty.
// - Duty write in the very transfer cycle cancels that transfer.
// - timer_run low stops and zeroes the counter; high counts on ticks.
// - Clock select picks fxp/1,4,16,64,4096 or slow oscillator/128.
// - Mode field 00 is interval, 10 is PWM; others not to be used.
// - idle_level_sel sets the output's default level.
// - out_enable in interval mode toggles output each cycle match.
// - Interval cycle match pulses match_irq and clears counter.
// - Interval mode ignores the duty compare completely.
// - Counting continues after clear; period is N+1 count clocks.
// - Counter starts within one count clock after timer_run is set, two in PWM.
// - Stopping forces match_irq and output inactive, or keeps them so.
// - Direction bit 0 drives, 1 floats; resets FFH, bits 7:6 fixed.
// - PWM cycle match clears, interrupts, output active, targets duty.
// - PWM duty match sets output inactive and targets cycle again.
// - A new duty value needs three count clocks before transfer.
// - PWM start masks the first count clock if PWM was selected while stopped; output stays inactive.
`timescale 1ns/1ps

module tmh_timer
  import tmh_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_slow_osc_clk,
  input wire logic [15:0] i_addr,
  input wire logic i_wr_en,
  input wire logic [7:0] i_wdata,
  input wire logic i_rd_en,
  output logic [7:0] o_rdata,
  output logic o_match_irq,
  output logic [5:0] o_port4_out,
  output logic [5:0] o_port4_oe
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [7:0] mode_r, mode_nxt;
  logic [7:0] cycle_r, cycle_nxt;
  logic [7:0] duty_r, duty_nxt;
  logic [7:0] duty_act_r, duty_act_nxt;
  logic duty_pend_r, duty_pend_nxt;
  logic [1:0] duty_age_r, duty_age_nxt;
  logic [7:0] dir_r, dir_nxt;
  logic [7:0] latch_r, latch_nxt;
  logic [7:0] count_r, count_nxt;
  logic out_act_r, out_act_nxt;
  logic first_mask_r, first_mask_nxt;
  logic irq_r, irq_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [11:0] pre_r, pre_nxt;
  logic [6:0] slow_cnt_r, slow_cnt_nxt;
  logic slow_s1_r, slow_s2_r, slow_s3_r;
  tmh_target_t tgt_r, tgt_nxt;

  // ----------------------------------------------------------------------
  // Decoded fields and strobes
  // ----------------------------------------------------------------------
  logic run;
  logic [2:0] cks;
  logic [1:0] op_mode;
  logic pwm;
  logic tick;
  logic slow_edge;
  logic wr_mode, wr_cycle, wr_duty, wr_dir, wr_latch;
  logic tout;

  assign run = mode_r[TMH_BIT_TIMER_RUN];
  assign cks = mode_r[TMH_POS_CLK_SELECT +: 3];
  assign op_mode = mode_r[TMH_POS_OP_MODE +: 2];
  assign pwm = (op_mode == TMH_MODE_PWM);
  assign slow_edge = slow_s2_r & ~slow_s3_r;

  // Address decode for writes on the CPU memory port.
  always_comb
  begin
    wr_mode = 1'b0;
    wr_cycle = 1'b0;
    wr_duty = 1'b0;
    wr_dir = 1'b0;
    wr_latch = 1'b0;
    if (!i_wr_en)
    begin
      wr_mode = 1'b0;
    end
    else if (i_addr == TMH_ADDR_TIMER_MODE_CONTROL)
    begin
      wr_mode = 1'b1;
    end
    else if (i_addr == TMH_ADDR_CYCLE_COMPARE)
    begin
      wr_cycle = 1'b1;
    end
    else if (i_addr == TMH_ADDR_DUTY_COMPARE)
    begin
      wr_duty = 1'b1;
    end
    else if (i_addr == TMH_ADDR_PORT4_DIRECTION)
    begin
      wr_dir = 1'b1;
    end
    else if (i_addr == TMH_ADDR_PORT4_LATCH)
    begin
      wr_latch = 1'b1;
    end
  end

  // Count tick selection. The prescaler runs free, so after timer_run
  // is set the first tick comes within one count clock period. Codes 6
  // and 7 give no tick at all and the counter simply stands.
  always_comb
  begin
    case (cks)
      TMH_CKS_DIV1: tick = 1'b1;
      TMH_CKS_DIV4: tick = &(pre_r | ~TMH_MASK_DIV4);
      TMH_CKS_DIV16: tick = &(pre_r | ~TMH_MASK_DIV16);
      TMH_CKS_DIV64: tick = &(pre_r | ~TMH_MASK_DIV64);
      TMH_CKS_DIV4096: tick = &(pre_r | ~TMH_MASK_DIV4096);
      TMH_CKS_SLOW128: tick = slow_edge && (slow_cnt_r == TMH_SLOW_LAST);
      default: tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Counter, compare chase, output level, duty transfer and registers.
  always_comb
  begin
    mode_nxt = mode_r;
    cycle_nxt = cycle_r;
    duty_nxt = duty_r;
    duty_act_nxt = duty_act_r;
    duty_pend_nxt = duty_pend_r;
    duty_age_nxt = duty_age_r;
    dir_nxt = dir_r;
    latch_nxt = latch_r;
    count_nxt = count_r;
    out_act_nxt = out_act_r;
    first_mask_nxt = first_mask_r;
    tgt_nxt = tgt_r;
    irq_nxt = 1'b0;
    pre_nxt = pre_r + 12'h001;
    slow_cnt_nxt = slow_cnt_r;
    rdata_nxt = rdata_r;

    if (slow_edge)
    begin
      slow_cnt_nxt = slow_cnt_r + 7'h01;
    end

    // Counting. Stopped means counter held at zero, output inactive.
    if (!run)
    begin
      count_nxt = 8'h00;
      out_act_nxt = 1'b0;
      tgt_nxt = TMH_TGT_CYCLE;
      first_mask_nxt = pwm;
      duty_pend_nxt = 1'b0;
    end
    else if (tick)
    begin
      if (duty_pend_r && duty_age_r != TMH_DUTY_XFER_TICKS)
      begin
        duty_age_nxt = duty_age_r + 2'h1;
      end
      if (first_mask_r)
      begin
        first_mask_nxt = 1'b0;
      end
      else if (tgt_r == TMH_TGT_CYCLE && count_r == cycle_r)
      begin
        count_nxt = 8'h00;
        irq_nxt = 1'b1;
        if (pwm)
        begin
          out_act_nxt = 1'b1;
          tgt_nxt = TMH_TGT_DUTY;
        end
        else
        begin
          out_act_nxt = ~out_act_r;
        end
      end
      else if (pwm && tgt_r == TMH_TGT_DUTY && count_r == duty_act_r)
      begin
        // Duty matches never exist in interval mode.
        count_nxt = count_r + 8'h01;
        out_act_nxt = 1'b0;
        tgt_nxt = TMH_TGT_CYCLE;
        // Transfer only an aged value, and never against a CPU write.
        if (duty_pend_r && !wr_duty &&
            duty_age_r >= TMH_DUTY_XFER_TICKS - 2'h1)
        begin
          duty_act_nxt = duty_r;
          duty_pend_nxt = 1'b0;
        end
      end
      else
      begin
        count_nxt = count_r + 8'h01;
      end
    end

    // Register writes.
    if (wr_mode)
    begin
      mode_nxt = i_wdata;
    end
    if (wr_cycle)
    begin
      cycle_nxt = i_wdata;
    end
    if (wr_duty)
    begin
      duty_nxt = i_wdata;
      if (run)
      begin
        duty_pend_nxt = 1'b1;
        duty_age_nxt = 2'h0;
      end
      else
      begin
        duty_act_nxt = i_wdata;
      end
    end
    if (wr_dir)
    begin
      dir_nxt = i_wdata | TMH_DIR_FIXED_ONES;
    end
    if (wr_latch)
    begin
      latch_nxt = i_wdata;
    end

    // Read data is captured one cycle after the read strobe.
    if (i_rd_en)
    begin
      if (i_addr == TMH_ADDR_TIMER_MODE_CONTROL)
      begin
        rdata_nxt = mode_r;
      end
      else if (i_addr == TMH_ADDR_CYCLE_COMPARE)
      begin
        rdata_nxt = cycle_r;
      end
      else if (i_addr == TMH_ADDR_DUTY_COMPARE)
      begin
        rdata_nxt = duty_r;
      end
      else if (i_addr == TMH_ADDR_PORT4_DIRECTION)
      begin
        rdata_nxt = dir_r;
      end
      else if (i_addr == TMH_ADDR_PORT4_LATCH)
      begin
        rdata_nxt = latch_r;
      end
      else
      begin
        rdata_nxt = 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // The first slow-clock stage feeds only the second one.
  always_ff @(posedge i_ref_clk)
  begin
    slow_s1_r <= i_slow_osc_clk;
    slow_s2_r <= slow_s1_r;
    slow_s3_r <= slow_s2_r;
  end

  // Synchronous reset loads constants only.
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_resetn)
    begin
      mode_r <= TMH_RST_TIMER_MODE_CONTROL;
      cycle_r <= TMH_RST_COMPARE;
      duty_r <= TMH_RST_COMPARE;
      duty_act_r <= TMH_RST_COMPARE;
      duty_pend_r <= 1'b0;
      duty_age_r <= 2'h0;
      dir_r <= TMH_RST_PORT4_DIRECTION;
      latch_r <= TMH_RST_PORT4_LATCH;
      count_r <= 8'h00;
      out_act_r <= 1'b0;
      first_mask_r <= 1'b0;
      tgt_r <= TMH_TGT_CYCLE;
      irq_r <= 1'b0;
      rdata_r <= 8'h00;
      pre_r <= 12'h000;
      slow_cnt_r <= 7'h00;
    end
    else
    begin
      mode_r <= mode_nxt;
      cycle_r <= cycle_nxt;
      duty_r <= duty_nxt;
      duty_act_r <= duty_act_nxt;
      duty_pend_r <= duty_pend_nxt;
      duty_age_r <= duty_age_nxt;
      dir_r <= dir_nxt;
      latch_r <= latch_nxt;
      count_r <= count_nxt;
      out_act_r <= out_act_nxt;
      first_mask_r <= first_mask_nxt;
      tgt_r <= tgt_nxt;
      irq_r <= irq_nxt;
      rdata_r <= rdata_nxt;
      pre_r <= pre_nxt;
      slow_cnt_r <= slow_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // The active level is the opposite of the idle level; with output
  // disabled the pin sits at its idle level.
  assign tout = mode_r[TMH_BIT_IDLE_LEVEL_SEL] ^
                (out_act_r & mode_r[TMH_BIT_OUT_ENABLE]);
  assign o_match_irq = irq_r;
  assign o_rdata = rdata_r;

  // The timer output is ORed onto the latch, so the latch bit must be 0.
  always_comb
  begin
    o_port4_out = latch_r[5:0];
    o_port4_out[TMH_BIT_TIMER_OUT_PIN] =
      latch_r[TMH_BIT_TIMER_OUT_PIN] | tout;
    o_port4_oe = ~dir_r[5:0];
  end

endmodule

// file: tb/test_tmh_timer.sv
// Self-checking bench for the interval and PWM timer.
`timescale 1ns/1ps

module test_tmh_timer
  import tmh_pkg::*;
;
  // --------------------------------------------------------------
  // Signals, model and tasks
  // --------------------------------------------------------------
  logic i_ref_clk = 1'b0, i_resetn = 1'b0, i_slow_osc_clk = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic i_wr_en = 1'b0, i_rd_en = 1'b0, p0;
  logic [7:0] i_wdata = 8'h00, o_rdata;
  logic o_match_irq;
  logic [5:0] o_port4_out, o_port4_oe;
  int n_fail = 0, n_checks = 0, cyc = 0, t, w, lat, n;
  logic [31:0] seed = 32'd37;
  logic [7:0] mdl [logic [15:0]];
  logic [15:0] al [$];
  int dv [6] = '{1, 4, 16, 64, 4096, 1024};

  always #12.5 i_ref_clk = ~i_ref_clk;
  // Slow clock of 8 core cycles, so its divided tick is exact.
  always #100 i_slow_osc_clk = ~i_slow_osc_clk;

  tmh_timer dut_u (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
    .i_slow_osc_clk(i_slow_osc_clk), .i_addr(i_addr), .i_wr_en(i_wr_en),
    .i_wdata(i_wdata), .i_rd_en(i_rd_en), .o_rdata(o_rdata),
    .o_match_irq(o_match_irq), .o_port4_out(o_port4_out),
    .o_port4_oe(o_port4_oe));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %0t value %h expected %h", $time, g, e);
    end
  endtask

  task automatic chki(input int g, input int e);
    n_checks++;
    if (g != e)
    begin
      n_fail++;
      $display("BAD %0t count %0d expected %0d", $time, g, e);
    end
  endtask

  // Writes also update the model; direction bits 7:6 read as ones.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    i_addr = a;
    i_wdata = d;
    i_wr_en = 1'b1;
    @(negedge i_ref_clk);
    i_wr_en = 1'b0;
    // Unmapped addresses keep reading as zero, so the model skips them.
    if (mdl.exists(a) || a == TMH_ADDR_PORT4_LATCH)
      mdl[a] = (a == TMH_ADDR_PORT4_DIRECTION) ? d | TMH_DIR_FIXED_ONES : d;
  endtask

  task automatic rd(input logic [15:0] a);
    @(negedge i_ref_clk);
    i_addr = a;
    i_rd_en = 1'b1;
    @(negedge i_ref_clk);
    i_rd_en = 1'b0;
    chk8(o_rdata, mdl.exists(a) ? mdl[a] : 8'h00);
  endtask

  task automatic wirq(output int c);
    c = 0;
    do
    begin
      @(negedge i_ref_clk);
      c++;
    end
    while (o_match_irq !== 1'b1 && c < 20000);
  endtask

  // Counts the cycles the pin stays active, idle level being low.
  task automatic width(output int c);
    c = 0;
    while (o_port4_out[2] === 1'b1 && c < 300)
    begin
      c++;
      @(negedge i_ref_clk);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // A hang is cut short well above the longest expected run.
  always @(posedge i_ref_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_fail++;
      stop_test();
    end
  end

  // --------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------
  initial
  begin
    al = '{TMH_ADDR_PORT4_DIRECTION, TMH_ADDR_TIMER_MODE_CONTROL,
      TMH_ADDR_CYCLE_COMPARE, TMH_ADDR_DUTY_COMPARE, 16'hFF71};
    mdl[al[0]] = 8'hFF;
    mdl[al[1]] = 8'h00;
    mdl[al[2]] = 8'h00;
    mdl[al[3]] = 8'h00;
    repeat (3) @(negedge i_ref_clk);
    i_resetn = 1'b1;
    foreach (al[k]) rd(al[k]);
    for (int r = 0; r < 3; r++)
    begin
      foreach (al[k]) wr(al[k], 8'(rnd()) & ((k == 1) ? 8'h0B : 8'hFF));
      foreach (al[k]) rd(al[k]);
      chk8({2'h0, o_port4_oe}, {2'h0, ~mdl[al[0]][5:0]});
    end
    wr(TMH_ADDR_PORT4_DIRECTION, 8'hFB);
    wr(TMH_ADDR_PORT4_LATCH, 8'h00);
    for (int v = 1; v >= 0; v--)
    begin
      wr(TMH_ADDR_TIMER_MODE_CONTROL, 8'h01 | 8'(v << 1));
      @(negedge i_ref_clk);
      chk8({7'h00, o_port4_out[2]}, 8'(v));
    end
    wr(TMH_ADDR_DUTY_COMPARE, 8'h00);
    for (int s = 0; s < 6; s++)
    begin
      n = (s == 0) ? 9 : 1;
      wr(TMH_ADDR_CYCLE_COMPARE, 8'(n));
      wr(TMH_ADDR_TIMER_MODE_CONTROL, 8'(s << 4) | 8'h01);
      wr(TMH_ADDR_TIMER_MODE_CONTROL, 8'(s << 4) | 8'h81);
      wirq(t);
      if (s == 0)
        lat = t;
      p0 = o_port4_out[2];
      wirq(t);
      chki(t, (n + 1) * dv[s]);
      chk8({7'h00, o_port4_out[2]}, {7'h00, ~p0});
      wr(TMH_ADDR_TIMER_MODE_CONTROL, 8'(s << 4) | 8'h01);
      @(negedge i_ref_clk);
      chk8({6'h00, o_port4_out[2], o_match_irq}, 8'h00);
    end
    chki(lat <= 11, 1);
    // The PWM start takes one count clock longer than the first interval start.
    wr(TMH_ADDR_CYCLE_COMPARE, 8'h09);
    wr(TMH_ADDR_TIMER_MODE_CONTROL, 8'h09);
    wr(TMH_ADDR_DUTY_COMPARE, 8'h03);
    wr(TMH_ADDR_TIMER_MODE_CONTROL, 8'h89);
    wirq(t);
    chki(t, lat + 1);
    width(w);
    chki(w, 4);
    wirq(t);
    @(negedge i_ref_clk);
    wr(TMH_ADDR_DUTY_COMPARE, 8'h05);
    wirq(t);
    // Three cycles of this period went by in the idle edge and the write.
    chki(t + 3, 10);
    width(w);
    chki(w, 4);
    wirq(t);
    width(w);
    chki(w, 6);
    wr(TMH_ADDR_TIMER_MODE_CONTROL, 8'h09);
    @(negedge i_ref_clk);
    chk8({6'h00, o_port4_out[2], o_match_irq}, 8'h00);
    stop_test();
  end
endmodule

bind tmh_timer tmh_timer_props chk_u (.i_ref_clk(i_ref_clk),
  .i_resetn(i_resetn), .i_slow_osc_clk(i_slow_osc_clk), .i_addr(i_addr),
  .i_wr_en(i_wr_en), .i_wdata(i_wdata), .i_rd_en(i_rd_en),
  .o_rdata(o_rdata), .o_match_irq(o_match_irq),
  .o_port4_out(o_port4_out), .o_port4_oe(o_port4_oe));

// file: tb/tmh_timer_properties.sv
// Port-level checker for the interval and PWM timer.
`timescale 1ns/1ps

module tmh_timer_props
  import tmh_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_slow_osc_clk,
  input wire logic [15:0] i_addr,
  input wire logic i_wr_en,
  input wire logic [7:0] i_wdata,
  input wire logic i_rd_en,
  input wire logic [7:0] o_rdata,
  input wire logic o_match_irq,
  input wire logic [5:0] o_port4_out,
  input wire logic [5:0] o_port4_oe
);
  // --------------------------------------------------------------
  // Shadow state
  // --------------------------------------------------------------
  logic [7:0] md_r, md_nxt, cy_r, cy_nxt, du_r, du_nxt, dr_r, dr_nxt;
  logic [7:0] lt_r, lt_nxt, exp_rd;
  logic [8:0] gap_r, gap_nxt;
  logic seen_r, seen_nxt, routed, pwm;
  logic [15:0] wa;
  assign wa = i_wr_en ? i_addr : 16'h0000;
  assign routed = !dr_r[2] && !lt_r[2];
  assign pwm = md_r[3:2] == TMH_MODE_PWM;

  // Shadows follow writes; a config write voids the period history.
  always_comb
  begin
    md_nxt = (wa == TMH_ADDR_TIMER_MODE_CONTROL) ? i_wdata : md_r;
    cy_nxt = (wa == TMH_ADDR_CYCLE_COMPARE) ? i_wdata : cy_r;
    du_nxt = (wa == TMH_ADDR_DUTY_COMPARE) ? i_wdata : du_r;
    lt_nxt = (wa == TMH_ADDR_PORT4_LATCH) ? i_wdata : lt_r;
    dr_nxt = (wa == TMH_ADDR_PORT4_DIRECTION) ?
      (i_wdata | TMH_DIR_FIXED_ONES) : dr_r;
    gap_nxt = o_match_irq ? 9'h000 : gap_r + {8'h00, ~&gap_r};
    seen_nxt = (i_wr_en && i_addr[15:4] == 12'hFF7) ? 1'h0 :
      (seen_r | o_match_irq);
    if (wa == TMH_ADDR_CYCLE_COMPARE)
    begin
      seen_nxt = 1'h0;
    end
  end

  // Register the shadows with the device's own reset values.
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_resetn)
    begin
      md_r <= TMH_RST_TIMER_MODE_CONTROL;
      cy_r <= TMH_RST_COMPARE;
      du_r <= TMH_RST_COMPARE;
      lt_r <= TMH_RST_PORT4_LATCH;
      dr_r <= TMH_RST_PORT4_DIRECTION;
      gap_r <= 9'h000;
      seen_r <= 1'h0;
    end
    else
    begin
      md_r <= md_nxt;
      cy_r <= cy_nxt;
      du_r <= du_nxt;
      lt_r <= lt_nxt;
      dr_r <= dr_nxt;
      gap_r <= gap_nxt;
      seen_r <= seen_nxt;
    end
  end

  // Expected read data; the latch is left out on purpose.
  always_comb
  begin
    case (i_addr)
      TMH_ADDR_PORT4_DIRECTION: exp_rd = dr_r;
      TMH_ADDR_TIMER_MODE_CONTROL: exp_rd = md_r;
      TMH_ADDR_CYCLE_COMPARE: exp_rd = cy_r;
      TMH_ADDR_DUTY_COMPARE: exp_rd = du_r;
      default: exp_rd = 8'h00;
    endcase
  end

  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  read_back_a: assert property (
    i_rd_en && i_addr != TMH_ADDR_PORT4_LATCH |=> o_rdata == $past(exp_rd))
    else $error("read data differs from register");
  drive_en_a: assert property (o_port4_oe == ~dr_r[5:0])
    else $error("pin enable differs from direction");
  stop_quiet_a: assert property (!$past(md_r[7]) |-> !o_match_irq)
    else $error("match pulse while stopped");
  idle_level_a: assert property (
    $stable(md_r) && !md_r[7] && routed |-> o_port4_out[2] == md_r[1])
    else $error("stopped pin not at idle level");
  period_len_a: assert property (
    o_match_irq && seen_r && md_r[7:4] == 4'h8 |-> gap_r == {1'h0, cy_r})
    else $error("match period is not N plus one");
  square_wave_a: assert property (
    $stable(md_r) && $past(md_r, 2) == md_r && !md_r[3] && routed &&
    $stable(routed) |->
    $changed(o_port4_out[2]) == (o_match_irq && md_r[0]))
    else $error("interval pin toggle mismatch");
  pwm_rise_a: assert property (
    o_match_irq && pwm && md_r[0] && routed |-> o_port4_out[2] != md_r[1])
    else $error("pwm output not active at cycle match");
  pwm_fall_a: assert property (
    $stable(md_r) && pwm && md_r[7] && routed && $stable(routed) &&
    $changed(o_port4_out[2]) && o_port4_out[2] == md_r[1] |-> !o_match_irq)
    else $error("pwm duty end raised a match pulse");

  cover property (o_match_irq && pwm);
  cover property (o_match_irq && !md_r[3] && md_r[0]);
  cover property (i_rd_en && i_addr == TMH_ADDR_DUTY_COMPARE);
endmodule
